// >>> hw/otg_activity_monitor.sv
// Purpose: Produces the activity-pending indication
// Assumes: Activity input is a level from the serial engine
// Notes: Flag reads zero unless the sleep guard is set
`timescale 1ns/1ps
module otg_activity_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Status inputs
  input wire logic sleep_guard,
  input wire logic bus_activity,
  // Flag
  output logic activity_pending_flag
);
  logic next_activity_pending_flag;

  always_comb
  begin
    // Hardware alone sets and clears it
    next_activity_pending_flag = sleep_guard & bus_activity;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      activity_pending_flag <= 1'b0;
    else
      activity_pending_flag <= next_activity_pending_flag;
  end
endmodule

// >>> hw/otg_line_pkg.sv
// Purpose: Shared constants for the dual-role line and power control block
// Assumes: 32-bit AXI4-Lite register bus, registers one word each
// Notes: Offsets are byte addresses
package otg_line_pkg;
  localparam logic [3:0] off_line_control = 4'h0;
  localparam logic [3:0] off_power_control = 4'h4;
  localparam logic [3:0] off_role_control = 4'h8;
  localparam logic [3:0] off_line_status = 4'hc;
  // Line control field positions
  localparam int pos_dplus_pullup = 7;
  localparam int pos_dminus_pullup = 6;
  localparam int pos_dplus_pulldown = 5;
  localparam int pos_dminus_pulldown = 4;
  localparam int pos_bus_power_on = 3;
  localparam int pos_dual_role = 2;
  localparam int pos_bus_charge = 1;
  localparam int pos_bus_discharge = 0;
  // Power control field positions
  localparam int pos_activity_pending = 7;
  localparam int pos_sleep_guard = 4;
  localparam int pos_suspend = 1;
  localparam int pos_operation_enable = 0;
  // Role control field positions
  localparam int pos_host_role = 3;
  localparam int pos_module_enable = 0;
  // Writable masks
  localparam logic [15:0] mask_line_control = 16'h00ff;
  localparam logic [15:0] mask_power_control = 16'h0013;
  localparam logic [15:0] mask_role_control = 16'h0009;
  // Reset values
  localparam logic [7:0] reset_line_control = 8'h00;
  localparam logic [15:0] reset_power_control = 16'h0000;
  localparam logic [15:0] reset_role_control = 16'h0000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// >>> hw/otg_resistor_select.sv
// Purpose: Chooses the D+/D- pull-up and pull-down settings
// Assumes: Role inputs are synchronous to aclk
// Notes: Purely combinational; outputs are registered by the caller
`timescale 1ns/1ps
module otg_resistor_select (
  // Software settings
  input wire logic dual_role_feature_enable,
  input wire logic [3:0] soft_resistors,
  // Hardware role
  input wire logic host_role_enable,
  input wire logic module_enable,
  // Chosen settings: dp up, dm up, dp down, dm down
  output logic [3:0] resistors
);
  always_comb
  begin
    if (dual_role_feature_enable)
      resistors = soft_resistors;
    else if (host_role_enable)
      resistors = 4'h3; // host: both pull-downs
    else if (module_enable)
      resistors = 4'h8; // full-speed device: D+ pull-up
    else
      resistors = 4'h0;
  end
endmodule

// >>> hw/usb_otg_power_line_control.sv
// Purpose: Register file and line control of a USB dual-role port
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: Line outputs are registered from the register settings
//
// How it works
// - Dual-role on: software resistor bits apply
// - Dual-role off: roles drive resistors
// - Pull-down bits switch their line's resistor
// - Pending reads one only under sleep guard
// - Pending zero means free to suspend
// - Pending is hardware-owned, writes ignored
// - Suspend gates clock, transceiver low power
// - Operation enable powers the module, gating lines and supplies
// - Unimplemented bits read zero
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module usb_otg_power_line_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Engine status
  input wire logic bus_activity,
  input wire logic suspend_clear,
  // Line resistors
  output logic dplus_pullup_enable,
  output logic dminus_pullup_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  // Supply control
  output logic bus_power_on,
  output logic bus_charge_select,
  output logic bus_discharge_enable,
  // Module power
  output logic usb_clock_gate,
  output logic transceiver_low_power,
  output logic module_powered
);
  // Register file
  logic [7:0] otg_line_control;
  logic [15:0] usb_power_control;
  logic [15:0] role_control;
  logic [7:0] next_otg_line_control;
  logic [15:0] next_usb_power_control;
  logic [15:0] next_role_control;

  // Bus handshake
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] aw_addr;
  logic [3:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic next_rvalid;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic do_write;

  // Line and power outputs
  logic activity_pending_flag;
  logic [3:0] resistors;
  logic [3:0] next_lines;
  logic [3:0] lines;
  logic [2:0] next_supply;
  logic [2:0] next_power_out;

  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = addr == otg_line_pkg::off_line_control ||
      addr == otg_line_pkg::off_power_control ||
      addr == otg_line_pkg::off_role_control ||
      addr == otg_line_pkg::off_line_status;
  endfunction

  // Merge byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic [31:0] data, input logic [3:0] strb,
    input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~m) | (data[15:0] & m);
  endfunction

  otg_resistor_select u_select (
    .dual_role_feature_enable(otg_line_control[otg_line_pkg::pos_dual_role]),
    .soft_resistors(otg_line_control[7:4]),
    .host_role_enable(role_control[otg_line_pkg::pos_host_role]),
    .module_enable(role_control[otg_line_pkg::pos_module_enable]),
    .resistors(resistors)
  );

  otg_activity_monitor u_activity (
    .aclk(aclk),
    .aresetn(aresetn),
    .sleep_guard(usb_power_control[otg_line_pkg::pos_sleep_guard]),
    .bus_activity(bus_activity),
    .activity_pending_flag(activity_pending_flag)
  );

  // Address and data are each taken once, in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  // Bus handshake state
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    // Taken before the held flags drop, so no loop through them
    do_write = next_aw_held && next_w_held && !bvalid;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(next_aw_addr) ? otg_line_pkg::resp_okay
        : otg_line_pkg::resp_slverr;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(araddr) ? otg_line_pkg::resp_okay
        : otg_line_pkg::resp_slverr;
      case (araddr)
        otg_line_pkg::off_line_control:
          next_rdata = {24'h000000, otg_line_control};
        otg_line_pkg::off_power_control:
          next_rdata = {24'h000000, activity_pending_flag,
            usb_power_control[6:0]};
        otg_line_pkg::off_role_control:
          next_rdata = {16'h0000, role_control};
        otg_line_pkg::off_line_status:
          next_rdata = {28'h0000000, lines};
        default:
          next_rdata = 32'h00000000;
      endcase
    end
  end

  // Register file state
  always_comb
  begin
    next_otg_line_control = otg_line_control;
    next_usb_power_control = usb_power_control;
    next_role_control = role_control;
    if (do_write)
    begin
      case (next_aw_addr)
        otg_line_pkg::off_line_control:
          next_otg_line_control = 8'(merge({8'h00, otg_line_control},
            next_w_data, next_w_strb, otg_line_pkg::mask_line_control));
        otg_line_pkg::off_power_control:
          // Pending bit is not in the mask, so writes miss it
          next_usb_power_control = merge(usb_power_control, next_w_data,
            next_w_strb, otg_line_pkg::mask_power_control);
        otg_line_pkg::off_role_control:
          next_role_control = merge(role_control, next_w_data,
            next_w_strb, otg_line_pkg::mask_role_control);
        default:
          next_role_control = role_control;
      endcase
    end
    // Hardware clear of suspend beats a software set
    if (suspend_clear)
      next_usb_power_control[otg_line_pkg::pos_suspend] = 1'b0;
  end

  always_comb
  begin
    // Disabled module floats nothing: resistors and supplies off
    if (usb_power_control[otg_line_pkg::pos_operation_enable])
    begin
      next_lines = resistors;
      next_supply = {otg_line_control[otg_line_pkg::pos_bus_power_on],
        otg_line_control[otg_line_pkg::pos_bus_charge],
        otg_line_control[otg_line_pkg::pos_bus_discharge]};
    end
    else
    begin
      next_lines = 4'h0;
      next_supply = 3'h0;
    end
    next_power_out = {
      usb_power_control[otg_line_pkg::pos_suspend],
      usb_power_control[otg_line_pkg::pos_suspend],
      usb_power_control[otg_line_pkg::pos_operation_enable]};
  end

  // Bus handshake registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= otg_line_pkg::resp_okay;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= otg_line_pkg::resp_okay;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Register file, hardware clear already folded in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      otg_line_control <= otg_line_pkg::reset_line_control;
      usb_power_control <= otg_line_pkg::reset_power_control;
      role_control <= otg_line_pkg::reset_role_control;
    end
    else
    begin
      otg_line_control <= next_otg_line_control;
      usb_power_control <= next_usb_power_control;
      role_control <= next_role_control;
    end
  end

  // Pins follow the registers one cycle later, free of glitches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lines <= 4'h0;
      {bus_power_on, bus_charge_select, bus_discharge_enable} <= 3'h0;
      {usb_clock_gate, transceiver_low_power, module_powered} <= 3'h0;
    end
    else
    begin
      lines <= next_lines;
      {bus_power_on, bus_charge_select, bus_discharge_enable} <= next_supply;
      {usb_clock_gate, transceiver_low_power, module_powered} <=
        next_power_out;
    end
  end

  assign {dplus_pullup_enable, dminus_pullup_enable,
    dplus_pulldown_enable, dminus_pulldown_enable} = lines;
endmodule

// >>> verif/otg_line_monitor.sv
// Purpose: Port checker for the dual-role line control block
// Assumes: Write address and data are offered together
// Notes: Role bits are tracked from observed writes
`timescale 1ns/1ps
module otg_line_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [3:0] awaddr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [3:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // Line side
  input wire logic suspend_clear,
  input wire logic dplus_pullup_enable,
  input wire logic dminus_pullup_enable,
  input wire logic dplus_pulldown_enable,
  input wire logic dminus_pulldown_enable,
  input wire logic bus_power_on,
  input wire logic bus_charge_select,
  input wire logic bus_discharge_enable,
  input wire logic usb_clock_gate,
  input wire logic module_powered
);
  logic wr, wr_line, wr_pwr, rd_pwr, host, men;
  logic [3:0] rd_addr, res, hw_res;
  logic [31:0] wd;
  // Control bits all sit in the low byte lane
  assign wr = awvalid && awready && wstrb[0];
  assign wr_line = wr && awaddr == otg_line_pkg::off_line_control;
  assign wr_pwr = wr && awaddr == otg_line_pkg::off_power_control;
  assign rd_pwr = rd_addr == otg_line_pkg::off_power_control;
  assign res = {dplus_pullup_enable, dminus_pullup_enable,
    dplus_pulldown_enable, dminus_pulldown_enable};
  assign hw_res = host ? 4'h3 : (men ? 4'h8 : 4'h0);
  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
      rd_addr <= araddr;
    if (wr)
      wd <= wdata;
    if (!aresetn)
      {host, men} <= 2'h0;
    else if (wr && awaddr == otg_line_pkg::off_role_control)
      {host, men} <= {wdata[3], wdata[0]};
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_off_quiet;
    !module_powered |-> res == 4'h0 && !bus_power_on
      && !bus_charge_select && !bus_discharge_enable;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("line active while off");
  property p_soft;
    wr_line && wdata[2] && module_powered |-> ##2 res == wd[7:4];
  endproperty
  a_soft: assert property (p_soft)
    else $error("software resistors not applied");
  property p_hw;
    wr_line && !wdata[2] && module_powered |-> ##2 res == hw_res;
  endproperty
  a_hw: assert property (p_hw)
    else $error("role resistors wrong");
  property p_supply;
    wr_line && module_powered |-> ##2 {bus_power_on, bus_charge_select,
      bus_discharge_enable} == {wd[3], wd[1], wd[0]};
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply outputs wrong");
  property p_enable;
    wr_pwr |-> ##2 module_powered == wd[0];
  endproperty
  a_enable: assert property (p_enable)
    else $error("module power wrong");
  property p_suspend;
    wr_pwr && !suspend_clear |-> ##2 usb_clock_gate == wd[1];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("clock gate wrong");
  property p_upper;
    rvalid && rd_addr[3] == 1'b0 |->
      (rdata & (rd_pwr ? 32'hffffff6c : 32'hffffff00)) == 32'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("unused bits not zero");
  property p_pending;
    rvalid && rd_pwr && rdata[7] |-> rdata[4];
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending without guard");
  cover property (wr_line && wdata[2]);
  cover property (suspend_clear && usb_clock_gate);
  cover property (rvalid && rdata[7]);
endmodule
bind usb_otg_power_line_control otg_line_monitor mon (.aclk, .aresetn,
  .awvalid, .awready, .awaddr, .wdata, .wstrb, .arvalid, .arready,
  .araddr, .rvalid, .rdata, .suspend_clear, .dplus_pullup_enable,
  .dminus_pullup_enable, .dplus_pulldown_enable, .dminus_pulldown_enable,
  .bus_power_on, .bus_charge_select, .bus_discharge_enable,
  .usb_clock_gate, .module_powered);

// >>> verif/usb_otg_power_line_control_test.sv
// Purpose: Self-checking bench for the dual-role line control block
// Assumes: One bus transfer at a time, all byte lanes written except one write with the low lane off
// Notes: Read results are queued and checked by a watcher
`timescale 1ns/1ps
module usb_otg_power_line_control_test;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, talk = 1'b0;
  logic suspend_clear = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, bus_activity;
  logic dplus_pullup_enable, dminus_pullup_enable, dplus_pulldown_enable;
  logic dminus_pulldown_enable, bus_power_on, bus_charge_select;
  logic bus_discharge_enable, usb_clock_gate, transceiver_low_power;
  logic module_powered;
  logic [33:0] exp_q[$];
  int seed = 32'h63990acf;
  int err_total = 0;
  int checks_done = 0;
  always #2.5 aclk = ~aclk;
  usb_otg_power_line_control DUT (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .bus_activity, .suspend_clear, .dplus_pullup_enable,
    .dminus_pullup_enable, .dplus_pulldown_enable, .dminus_pulldown_enable,
    .bus_power_on, .bus_charge_select, .bus_discharge_enable,
    .usb_clock_gate, .transceiver_low_power, .module_powered);
  usb_peer_model peer (.aclk, .dplus_pullup_enable, .dminus_pullup_enable,
    .talk, .bus_activity);
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Every aligned word of the map exists; others answer with an error
  function automatic logic [1:0] exp_resp(input logic [3:0] a);
    return (a[1:0] == 2'h0) ? otg_line_pkg::resp_okay
      : otg_line_pkg::resp_slverr;
  endfunction
  // Waits for the answer as long as it takes; the watchdog bounds it
  task wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(bresp, exp_resp(a));
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back({exp_resp(a), e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // Oldest note pairs with each read answer
  always @(posedge aclk)
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, exp_q.pop_front());
  initial
  begin
    #20000;
    err_total++;
    report_and_stop;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    wr(4'h4, 32'h1); // Enable before any role
    wr(4'h8, 32'h8); // Host role before host-only bits
    repeat (6)
    begin
      d = ($random(seed) & 32'hff) | 32'h4;
      wr(4'h0, d);
      rd(4'h0, d);
      rd(4'hc, d[7:4]);
      check({bus_power_on, bus_charge_select, bus_discharge_enable},
        {d[3], d[1], d[0]});
    end
    wr(4'h0, 32'h0);
    rd(4'hc, 32'h3);
    wr(4'h8, 32'h1);
    rd(4'hc, 32'h8);
    wr(4'h8, 32'h9); // Back to host before host-only bits
    wr(4'h0, 32'h84);
    talk <= 1'b1;
    rd(4'h4, 32'h1);
    wr(4'h4, 32'h11); // Guard raised before suspend
    rd(4'h4, 32'h91);
    talk <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(4'h4, 32'h91);
    rd(4'h4, 32'h11);
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'h13);
    check({usb_clock_gate, transceiver_low_power}, 2'h3);
    suspend_clear <= 1'b1;
    @(posedge aclk);
    suspend_clear <= 1'b0;
    rd(4'h4, 32'h11);
    wr(4'h0, 32'hffffffff);
    rd(4'h0, 32'hff);
    wstrb <= 4'he;
    wr(4'h0, 32'h0); // Low lane off: nothing changes
    wstrb <= 4'hf;
    rd(4'h0, 32'hff);
    wr(4'h2, 32'hffffffff); // Unaligned: error, no write
    rd(4'h6, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h8, 32'h0);
    wr(4'h4, 32'h0); // Roles cleared before disable
    rd(4'hc, 32'h0);
    check(module_powered, 1'b0);
    repeat (2) @(posedge aclk);
    report_and_stop;
  end
endmodule

// >>> verif/usb_peer_model.sv
// Purpose: USB peer seen through the line resistors
// Assumes: Peer only signals once a pull-up shows attachment
// Notes: Activity is registered, as the engine would see it
`timescale 1ns/1ps
module usb_peer_model (
  // Clock
  input wire logic aclk,
  // Line resistors and peer traffic
  input wire logic dplus_pullup_enable,
  input wire logic dminus_pullup_enable,
  input wire logic talk,
  // Engine view
  output logic bus_activity
);
  initial bus_activity = 1'b0;
  always @(posedge aclk)
    bus_activity <= talk && (dplus_pullup_enable || dminus_pullup_enable);
endmodule
